//--- design/dio_out_drv.sv
// Output level driver: registered state xor active-low polarity
// Assumes clk_sys and rst_n shared with the register front end
`timescale 1ns/100ps
module dio_out_drv (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  dio_if.drv        io
);

  // ----------------------------------------------------------------
  // Line levels
  // ----------------------------------------------------------------
  logic [dio_pkg::DIO_NUM_OUT-1:0] lines_r;
  wire  [dio_pkg::DIO_NUM_OUT-1:0] lines_nxt;

  assign lines_nxt = io.state ^ io.pol_low;  // [RL3] [RL7]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lines_r <= dio_pkg::DIO_LINES_RST;  // [RL6]
    end else begin
      lines_r <= lines_nxt;  // [RL7]
    end
  end

  assign io.lines = lines_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic seen_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_r <= 1'b0;
    end else begin
      seen_r <= 1'b1;
    end
  end

  chk_reset_high: assert property (  // [RL6]
    @(posedge clk_sys) disable iff (!rst_n)
    !seen_r |-> lines_r == dio_pkg::DIO_LINES_RST)
    else $error("output lines not high after reset");

  chk_on_level: assert property (  // [RL2]
    @(posedge clk_sys) disable iff (!rst_n)
    (io.state[0] && !io.pol_low[0]) |=> lines_r[0])
    else $error("active-high on channel not driven high");

endmodule : dio_out_drv

//--- design/dio_port.sv
// Digital I/O port top: AXI4-Lite slave, four outputs, one input
// Assumes synchronous inputs on clk_sys, async active-low reset
//
// Behaviour
// RL1 - Four output channels, on/off readable and writable
// RL2 - Per-channel polarity: active-high or active-low
// RL3 - Line level from state combined with polarity
// RL4 - One input channel, fixed active-high sense
// RL5 - Input readable anytime without output side effects
// RL6 - Reset returns every output line high
// RL7 - Line is state xor polarity, registered
`timescale 1ns/100ps
module dio_port (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        input_line,
  output logic             output_line_one,
  output logic             output_line_two,
  output logic             output_line_three,
  output logic             output_line_four
);

  localparam int N = dio_pkg::DIO_NUM_OUT;

  dio_if io ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [3:0] a);
    is_mapped = (a == dio_pkg::DIO_OFS_STATE)
             || (a == dio_pkg::DIO_OFS_POLARITY)
             || (a == dio_pkg::DIO_OFS_INPUT)
             || (a == dio_pkg::DIO_OFS_LINES);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic          aw_full_r;
  logic          w_full_r;
  logic [3:0]    awaddr_r;
  logic [31:0]   wdata_r;
  logic [3:0]    wstrb_r;
  logic          awready_r;
  logic          wready_r;
  logic          bvalid_r;
  logic [1:0]    bresp_r;
  logic [N-1:0]  state_r;
  logic [N-1:0]  pol_r;

  wire aw_hs  = s_axi_awvalid && awready_r;
  wire w_hs   = s_axi_wvalid && wready_r;
  wire do_wr  = aw_full_r && w_full_r && !bvalid_r;
  wire aw_full_nxt = aw_full_r ? !do_wr : aw_hs;
  wire w_full_nxt  = w_full_r ? !do_wr : w_hs;
  wire lane0  = wstrb_r[0];
  wire wr_state = do_wr && lane0 && (awaddr_r == dio_pkg::DIO_OFS_STATE);
  wire wr_pol   = do_wr && lane0
                  && (awaddr_r == dio_pkg::DIO_OFS_POLARITY);
  wire [N-1:0] state_nxt = wr_state ? wdata_r[N-1:0] : state_r;
  wire [N-1:0] pol_nxt   = wr_pol ? wdata_r[N-1:0] : pol_r;
  wire [1:0] bresp_nxt = is_mapped(awaddr_r) ? dio_pkg::DIO_RESP_OKAY
                                             : dio_pkg::DIO_RESP_SLVERR;
  wire bvalid_nxt = do_wr || (bvalid_r && !s_axi_bready);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      awaddr_r  <= 4'h0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bresp_r   <= dio_pkg::DIO_RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      awready_r <= !aw_full_nxt;
      wready_r  <= !w_full_nxt;
      bvalid_r  <= bvalid_nxt;
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        bresp_r <= bresp_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel state and polarity
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= dio_pkg::DIO_STATE_RST;  // [RL6]
      pol_r   <= dio_pkg::DIO_POL_RST;    // [RL6]
    end else begin
      state_r <= state_nxt;  // [RL1]
      pol_r   <= pol_nxt;    // [RL2]
    end
  end

  assign io.state   = state_r;
  assign io.pol_low = pol_r;

  dio_out_drv u_drv (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .io      (io)
  );

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic          arready_r;
  logic          rvalid_r;
  logic [31:0]   rdata_r;
  logic [1:0]    rresp_r;

  wire ar_hs = s_axi_arvalid && arready_r;
  wire rvalid_nxt = ar_hs || (rvalid_r && !s_axi_rready);
  wire sel_state = (s_axi_araddr == dio_pkg::DIO_OFS_STATE);
  wire sel_pol   = (s_axi_araddr == dio_pkg::DIO_OFS_POLARITY);
  wire sel_in    = (s_axi_araddr == dio_pkg::DIO_OFS_INPUT);
  wire sel_lines = (s_axi_araddr == dio_pkg::DIO_OFS_LINES);
  wire in_on     = input_line;  // [RL4]
  wire [31:0] rd_mux =
      sel_state ? {28'h0000000, state_r} :
      sel_pol   ? {28'h0000000, pol_r} :
      sel_in    ? {31'h00000000, in_on} :  // [RL5]
      sel_lines ? {28'h0000000, io.lines} : 32'h0000_0000;
  wire [1:0] rresp_nxt = is_mapped(s_axi_araddr) ? dio_pkg::DIO_RESP_OKAY
                                                 : dio_pkg::DIO_RESP_SLVERR;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= dio_pkg::DIO_RESP_OKAY;
    end else begin
      arready_r <= !rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_hs) begin
        rdata_r <= rd_mux;  // [RL5]
        rresp_r <= rresp_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready     = awready_r;
  assign s_axi_wready      = wready_r;
  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_arready     = arready_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rdata       = rdata_r;
  assign s_axi_rresp       = rresp_r;
  assign output_line_one   = io.lines[0];  // [RL3]
  assign output_line_two   = io.lines[1];
  assign output_line_three = io.lines[2];
  assign output_line_four  = io.lines[3];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_state_write: assert property (  // [RL1]
    @(posedge clk_sys) disable iff (!rst_n)
    wr_state |=> state_r == $past(wdata_r[N-1:0]))
    else $error("channel state not updated by write");

  chk_pol_write: assert property (  // [RL2]
    @(posedge clk_sys) disable iff (!rst_n)
    wr_pol |=> pol_r == $past(wdata_r[N-1:0]))
    else $error("polarity not updated by write");

  chk_line_derive: assert property (  // [RL3]
    @(posedge clk_sys) disable iff (!rst_n)
    io.lines == $past(state_r ^ pol_r) || !$past(rst_n))
    else $error("line level not state xor polarity");

  chk_input_sense: assert property (  // [RL4]
    @(posedge clk_sys) disable iff (!rst_n)
    (ar_hs && sel_in) |=> rvalid_r && s_axi_rdata[0] == $past(input_line))
    else $error("input read not active-high");

  chk_read_quiet: assert property (  // [RL5]
    @(posedge clk_sys) disable iff (!rst_n)
    (ar_hs && !do_wr) |=> state_r == $past(state_r)
                          && pol_r == $past(pol_r))
    else $error("read disturbed the output channels");

  chk_line_latency: assert property (  // [RL7]
    @(posedge clk_sys) disable iff (!rst_n)
    (wr_state && !wr_pol) |=> ##1 io.lines == ($past(wdata_r[N-1:0], 2)
                                               ^ $past(pol_r)))
    else $error("line not updated one clock after write");

  chk_bad_addr: assert property (  // [RL1]
    @(posedge clk_sys) disable iff (!rst_n)
    (do_wr && !is_mapped(awaddr_r)) |=> bvalid_r
                            && bresp_r == dio_pkg::DIO_RESP_SLVERR)
    else $error("unmapped write not answered with error");

  cov_state_write: cover property (
    @(posedge clk_sys) disable iff (!rst_n) wr_state ##2 io.lines != 4'hF);
  cov_input_on: cover property (
    @(posedge clk_sys) disable iff (!rst_n) ar_hs && sel_in && input_line);
  cov_pol_write: cover property (
    @(posedge clk_sys) disable iff (!rst_n) wr_pol);
  cov_unmapped: cover property (
    @(posedge clk_sys) disable iff (!rst_n) ar_hs && !is_mapped(s_axi_araddr));

endmodule : dio_port

//--- pkg/dio_if.sv
// Carrier between the register front end and the output driver
// Assumes both ends share one clock and reset
`timescale 1ns/100ps
interface dio_if;
  logic [dio_pkg::DIO_NUM_OUT-1:0] state;
  logic [dio_pkg::DIO_NUM_OUT-1:0] pol_low;
  logic [dio_pkg::DIO_NUM_OUT-1:0] lines;

  modport ctrl (output state, output pol_low, input lines);
  modport drv  (input state, input pol_low, output lines);
endinterface : dio_if

//--- pkg/dio_pkg.sv
// Constants for the four-channel digital I/O port with polarity
// Assumes a 32-bit AXI4-Lite register bus, byte-addressed words
package dio_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] DIO_OFS_STATE    = 4'h0;
  localparam logic [3:0] DIO_OFS_POLARITY = 4'h4;
  localparam logic [3:0] DIO_OFS_INPUT    = 4'h8;
  localparam logic [3:0] DIO_OFS_LINES    = 4'hC;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          DIO_NUM_OUT     = 4;
  localparam int          DIO_INPUT_BIT   = 0;
  localparam logic [3:0]  DIO_STATE_RST   = 4'h0;
  localparam logic [3:0]  DIO_POL_RST     = 4'hF;
  localparam logic [3:0]  DIO_LINES_RST   = 4'hF;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0]  DIO_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  DIO_RESP_SLVERR = 2'h2;

endpackage : dio_pkg

//--- verification/dio_ext_equip.sv
// External equipment model: drives the input line, watches outputs
// Assumes the bench names the level it wants on the input line
`timescale 1ns/100ps
module dio_ext_equip (
  input  wire logic       clk_sys,
  input  wire logic       want_on,
  input  wire logic [3:0] lines,
  output logic            input_line,
  output logic [3:0]      seen
);
  // ----------------------------------------------------------------
  // Input line driven in step with the system clock
  // ----------------------------------------------------------------
  initial input_line = 1'b0;
  always @(posedge clk_sys) begin
    input_line <= want_on;
  end
  assign seen = lines;
endmodule : dio_ext_equip

//--- verification/dio_port_test.sv
// Self-checking bench for the digital I/O port over AXI4-Lite
// Assumes the design files and the equipment model are compiled first
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  n_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module dio_port_test;
  logic        clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rd;
  logic [1:0]  resp;
  logic        want_on;
  wire logic        awready, wready, bvalid, arready, rvalid, input_line;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic        l1, l2, l3, l4;
  wire logic [3:0]  seen;
  int          n_errors, checks_done;
  logic [3:0]  st_t [5] = '{4'hF, 4'h5, 4'hA, 4'h3, 4'hC};
  logic [3:0]  pl_t [5] = '{4'hF, 4'hF, 4'h0, 4'h6, 4'h9};

  dio_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .input_line(input_line),
    .output_line_one(l1), .output_line_two(l2),
    .output_line_three(l3), .output_line_four(l4));
  dio_ext_equip u_equip (.clk_sys(clk_sys), .want_on(want_on),
    .lines({l4, l3, l2, l1}), .input_line(input_line), .seen(seen));

  // ----------------------------------------------------------------
  // Clock, bus tasks and closing
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    b_ok  = 1'b0;
    @(posedge clk_sys);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!b_ok) begin
      @(posedge clk_sys);
      if (bvalid === 1'b1) begin
        b_ok = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok  = 1'b0;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!ar_ok) begin
      @(posedge clk_sys);
      if (arready === 1'b1) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
    while (!r_ok) begin
      @(posedge clk_sys);
      if (rvalid === 1'b1) begin
        r_ok = 1'b1;
        r = rresp;
        d = rdata;
        rready <= 1'b0;
      end
    end
  endtask : axi_rd

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    axi_rd(a, rd, resp);
    `CHK("rresp", dio_pkg::DIO_RESP_OKAY, resp)
    `CHK("rdata", e, rd)
  endtask : rd_chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    #(100 * 20000);
    n_errors++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wstrb = 4'h0;
    wdata = 32'h0;
    want_on = 1'b0;
    n_errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 `CHK("lines", dio_pkg::DIO_LINES_RST, seen)
    rd_chk(dio_pkg::DIO_OFS_STATE, 32'h0);
    rd_chk(dio_pkg::DIO_OFS_POLARITY, 32'h0000000F);
    rd_chk(dio_pkg::DIO_OFS_LINES, 32'h0000000F);
    $display("test reset_values done");
    for (int k = 0; k < 5; k++) begin
      axi_wr(dio_pkg::DIO_OFS_POLARITY, {28'h0, pl_t[k]}, 4'hF, resp);
      axi_wr(dio_pkg::DIO_OFS_STATE, {28'h0, st_t[k]}, 4'hF, resp);
      #1 `CHK("lines", st_t[k] ^ pl_t[k], seen)
      `CHK("bresp", dio_pkg::DIO_RESP_OKAY, resp)
      rd_chk(dio_pkg::DIO_OFS_STATE, {28'h0, st_t[k]});
      rd_chk(dio_pkg::DIO_OFS_POLARITY, {28'h0, pl_t[k]});
      rd_chk(dio_pkg::DIO_OFS_LINES, {28'h0, st_t[k] ^ pl_t[k]});
    end
    $display("test state_polarity done");
    for (int v = 0; v < 2; v++) begin
      want_on <= v[0];
      repeat (2) @(posedge clk_sys);
      rd_chk(dio_pkg::DIO_OFS_INPUT, {31'h0, v[0]});
      `CHK("lines", 4'h5, seen)
    end
    $display("test input_read done");
    axi_wr(4'h1, 32'h0000000F, 4'hF, resp);
    `CHK("bresp", dio_pkg::DIO_RESP_SLVERR, resp)
    axi_rd(4'h1, rd, resp);
    `CHK("rresp", dio_pkg::DIO_RESP_SLVERR, resp)
    `CHK("rdata", 32'h0, rd)
    axi_wr(dio_pkg::DIO_OFS_STATE, 32'h0000000F, 4'h0, resp);
    `CHK("bresp", dio_pkg::DIO_RESP_OKAY, resp)
    rd_chk(dio_pkg::DIO_OFS_STATE, 32'h0000000C);
    $display("test refused_writes done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1 `CHK("lines", dio_pkg::DIO_LINES_RST, seen)
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(dio_pkg::DIO_OFS_STATE, 32'h0);
    rd_chk(dio_pkg::DIO_OFS_POLARITY, 32'h0000000F);
    `CHK("lines", dio_pkg::DIO_LINES_RST, seen)
    $display("test midrun_reset done");
    end_sim;
  end
endmodule : dio_port_test
